// ===== hdl/srs_defines.svh
// Shared constants for the speed reference selector
`ifndef SRS_DEFINES_SVH
`define SRS_DEFINES_SVH

// Reference scaling: 100% of speed is this many counts
`define SRS_REF_W 16
`define SRS_FULL_SCALE 16'h4000
`define SRS_ZERO_REF 16'h0000

// Timing: clock period and software cycle, both in ns
`define SRS_CLK_PERIOD_NS 32'h0000_0004
`define SRS_SW_CYCLE_NS 32'h0098_9680
`define SRS_NS_PER_S 32'h3B9A_CA00
`define SRS_SW_CYCLE_CLKS (`SRS_SW_CYCLE_NS / `SRS_CLK_PERIOD_NS)
`define SRS_CYCLES_PER_S (`SRS_NS_PER_S / `SRS_SW_CYCLE_NS)

// Reset value of the tick counter
`define SRS_CNT_ZERO 32'h0000_0000

`endif

// ===== hdl/srs_pkg.sv
// Types shared by the speed reference selector
package srs_pkg;

    typedef enum logic [1:0] {
        SRC_EXTERNAL,
        SRC_UNSIGNED_POT_MODE,
        SRC_SIGNED_POT_MODE
    } srs_src_t;

    typedef enum logic {
        AUX_CMD_FN_NONE,
        AUX_CMD_FN_PARAM_SET
    } srs_aux_fn_t;

    typedef enum logic {
        ADD_REF_NONE,
        ADD_REF_INTERNAL
    } srs_add_src_t;

    typedef enum logic {
        DIV_IDLE,
        DIV_BUSY
    } srs_div_state_t;

    typedef struct packed {
        logic increaseCmd;
        logic decreaseCmd;
        logic auxCmd;
        logic jogOneCmd;
        logic jogTwoCmd;
        logic startCmd;
    } srs_cmd_t;

    typedef struct packed {
        logic signed [15:0] jogRefA1;
        logic signed [15:0] jogRefA2;
        logic signed [15:0] jogRefB1;
        logic signed [15:0] jogRefB2;
    } srs_jog_t;

    typedef struct packed {
        logic [15:0] curKp;
        logic [15:0] curKi;
        logic [15:0] spdKp;
        logic [15:0] spdKi;
        logic [15:0] rampAccel;
        logic [15:0] rampDecel;
    } srs_tune_t;

endpackage

// ===== hdl/srs_cycle_timer.sv
// Software cycle tick generator
`timescale 1ns/1ps
`include "srs_defines.svh"
module srs_cycle_timer #(
    parameter logic [31:0] CYCLE_CLKS = `SRS_SW_CYCLE_CLKS
) (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rstSync_n,
    // Tick out
    output logic cycleTick
);
    logic [31:0] count_reg;
    logic [31:0] count_next;

    always_comb begin
        if (count_reg >= CYCLE_CLKS - 32'h0000_0001) begin
            count_next = `SRS_CNT_ZERO;
        end else begin
            count_next = count_reg + 32'h0000_0001;
        end
    end

    always_ff @(posedge clk_sys or negedge rstSync_n) begin
        if (!rstSync_n) begin
            count_reg <= `SRS_CNT_ZERO;
        end else begin
            count_reg <= count_next;
        end
    end

    assign cycleTick = (count_reg >= CYCLE_CLKS - 32'h0000_0001);
endmodule

// ===== hdl/srs_step_div.sv
// Restoring divider for the per-cycle ramp step
`timescale 1ns/1ps
module srs_step_div
    import srs_pkg::*;
#(
    parameter int NW = 16,
    parameter int DW = 32
) (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rstSync_n,
    // Request
    input wire logic divStart,
    input wire logic [NW-1:0] numer,
    input wire logic [DW-1:0] denom,
    // Result
    output logic divBusy,
    output logic [NW-1:0] quot
);
    srs_div_state_t state_reg, state_next;
    logic [NW-1:0] quot_reg, quot_next;
    logic [NW-1:0] num_reg, num_next;
    logic [NW-1:0] acc_reg, acc_next;
    logic [DW-1:0] den_reg, den_next;
    logic [DW:0] rem_reg, rem_next;
    logic [7:0] bit_reg, bit_next;
    logic [DW:0] trial;

    always_comb begin
        state_next = state_reg;
        quot_next = quot_reg;
        num_next = num_reg;
        acc_next = acc_reg;
        den_next = den_reg;
        rem_next = rem_reg;
        bit_next = bit_reg;
        trial = {rem_reg[DW-1:0], num_reg[NW-1]};
        case (state_reg)
            DIV_IDLE: begin
                if (divStart) begin
                    // A zero divisor means no ramp: jump the full numerator
                    if (denom == '0) begin
                        quot_next = numer;
                    end else begin
                        num_next = numer;
                        den_next = denom;
                        rem_next = '0;
                        bit_next = 8'(NW);
                        state_next = DIV_BUSY;
                    end
                end
            end
            DIV_BUSY: begin
                num_next = {num_reg[NW-2:0], 1'b0};
                if (trial >= {1'b0, den_reg}) begin
                    rem_next = trial - {1'b0, den_reg};
                    acc_next = {acc_reg[NW-2:0], 1'b1};
                end else begin
                    rem_next = trial;
                    acc_next = {acc_reg[NW-2:0], 1'b0};
                end
                bit_next = bit_reg - 8'h01;
                if (bit_reg == 8'h01) begin
                    // Publish only the finished quotient so the ramp keeps the old step meanwhile
                    quot_next = acc_next;
                    state_next = DIV_IDLE;
                end
            end
            default: state_next = DIV_IDLE;
        endcase
    end

    always_ff @(posedge clk_sys or negedge rstSync_n) begin
        if (!rstSync_n) begin
            state_reg <= DIV_IDLE;
            quot_reg <= '0;
            num_reg <= '0;
            acc_reg <= '0;
            den_reg <= '0;
            rem_reg <= '0;
            bit_reg <= '0;
        end else begin
            state_reg <= state_next;
            quot_reg <= quot_next;
            num_reg <= num_next;
            acc_reg <= acc_next;
            den_reg <= den_next;
            rem_reg <= rem_next;
            bit_reg <= bit_next;
        end
    end

    assign divBusy = (state_reg == DIV_BUSY);
    assign quot = quot_reg;
endmodule

// ===== hdl/srs_top.sv
// Speed reference selector: motor pot, jog references, tuning set switch
// How it works
// - Unsigned pot: 0..+100%, increase ramps up, decrease down, both or neither hold
// - Signed pot: -100..+100%, increase grows magnitude, decrease shrinks toward zero
// - Signed pot: aux sampled only at zero speed; active negative, inactive positive
// - Pot ramp rate comes from a programmable ramp time in seconds
// - With storage on, latest pot reference goes to the retained parameter
// - Quick restart on: power loss writes current pot reference to retained parameter
// - Zero-at-standstill on: stored pot reference cleared when speed reaches zero
// - Four internal jog references held as two pairs
// - Parameter-set function with aux active selects the alternate jog pair
// - Jog one releases the converter like start and forces first reference
// - Jog two releases the converter like start and forces second reference
// - Jog one beats jog two and start; jog two beats start
// - Internal-reference add source: jog value added to present reference
// - Two tuning sets kept for current, speed regulator and ramp
// - Parameter-set function: aux active uses second set, else first
`timescale 1ns/1ps
`include "srs_defines.svh"
module srs_top
    import srs_pkg::*;
#(
    parameter logic [31:0] SW_CYCLE_CLKS = `SRS_SW_CYCLE_CLKS,
    parameter logic [31:0] CYCLES_PER_S = `SRS_CYCLES_PER_S
) (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst_n,
    // Command terminals
    input wire srs_cmd_t cmdIn,
    // Configuration
    input wire srs_src_t speedRefSource,
    input wire srs_aux_fn_t auxCmdFunction,
    input wire srs_add_src_t addRefSource,
    input wire logic [15:0] potRampTime,
    input wire logic refStoreEnable,
    input wire logic storeJumper,
    input wire logic zeroAtStandstill,
    input wire logic quickRestartEn,
    input wire srs_jog_t jogRefs,
    input wire srs_tune_t tuneSetA,
    input wire srs_tune_t tuneSetB,
    // Drive state
    input wire logic speedZero,
    input wire logic powerLoss,
    input wire logic signed [15:0] externalRef,
    // Retained parameter
    input wire logic signed [15:0] storedReferenceIn,
    output logic signed [15:0] storedReference,
    output logic storedRefWrite,
    // Results
    output logic signed [15:0] speedRef,
    output logic signed [15:0] potRef,
    output logic runEnable,
    output logic paramSetTwo,
    output srs_tune_t tuneActive,
    output logic cycleTick
);
    localparam logic [16:0] FULL17 = {1'b0, `SRS_FULL_SCALE};

    logic [1:0] rstPipe_reg;
    logic rstSync_n;

    // Two-flop release of the asynchronous reset
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            rstPipe_reg <= 2'b00;
        end else begin
            rstPipe_reg <= {rstPipe_reg[0], 1'b1};
        end
    end
    assign rstSync_n = rstPipe_reg[1];

    srs_cycle_timer #(
        .CYCLE_CLKS(SW_CYCLE_CLKS)
    ) u_timer (
        .clk_sys(clk_sys),
        .rstSync_n(rstSync_n),
        .cycleTick(cycleTick)
    );

    // Ramp step: full scale divided by ramp time in software cycles
    logic [31:0] rampCycles;
    logic [15:0] rampSeen_reg, rampSeen_next;
    logic stepValid_reg, stepValid_next;
    logic divStart, divBusy;
    logic [15:0] stepSize;

    assign rampCycles = 32'(potRampTime * CYCLES_PER_S);
    // A ramp time of zero straight out of reset still needs one pass to load the step
    assign divStart = !divBusy && (!stepValid_reg || (potRampTime != rampSeen_reg));

    srs_step_div #(
        .NW(16),
        .DW(32)
    ) u_div (
        .clk_sys(clk_sys),
        .rstSync_n(rstSync_n),
        .divStart(divStart),
        .numer(`SRS_FULL_SCALE),
        .denom(rampCycles),
        .divBusy(divBusy),
        .quot(stepSize)
    );

    // Motor potentiometer state
    logic [15:0] potMag_reg, potMag_next;
    logic potNeg_reg, potNeg_next;
    logic loadPending_reg, loadPending_next;
    logic powerPrev_reg, powerPrev_next;
    logic storeWr_reg, storeWr_next;
    logic signed [15:0] storeData_reg, storeData_next;
    logic potModeOn, potUp, potDown, zeroClear, storeAllowed;
    logic [16:0] upSum;
    logic signed [15:0] potSigned;

    assign potModeOn = (speedRefSource == SRC_UNSIGNED_POT_MODE) || (speedRefSource == SRC_SIGNED_POT_MODE);
    assign potUp = cmdIn.increaseCmd && !cmdIn.decreaseCmd;
    assign potDown = cmdIn.decreaseCmd && !cmdIn.increaseCmd;
    assign zeroClear = zeroAtStandstill && speedZero && cycleTick;
    assign storeAllowed = refStoreEnable && storeJumper;
    assign upSum = {1'b0, potMag_reg} + {1'b0, stepSize};

    always_comb begin
        potMag_next = potMag_reg;
        potNeg_next = potNeg_reg;
        loadPending_next = 1'b0;
        powerPrev_next = powerLoss;
        if (loadPending_reg) begin
            // Pick up the retained value once, right after reset release
            if (storeAllowed) begin
                potNeg_next = storedReferenceIn[15];
                potMag_next = storedReferenceIn[15] ? 16'(-storedReferenceIn) : storedReferenceIn;
                if (potMag_next > `SRS_FULL_SCALE) begin
                    potMag_next = `SRS_FULL_SCALE;
                end
            end
        end else if (zeroClear) begin
            potMag_next = `SRS_ZERO_REF;
        end else if (cycleTick && potModeOn) begin
            if (potUp) begin
                potMag_next = (upSum > FULL17) ? `SRS_FULL_SCALE : upSum[15:0];
            end else if (potDown) begin
                potMag_next = (potMag_reg > stepSize) ? potMag_reg - stepSize : `SRS_ZERO_REF;
            end
            if (speedRefSource == SRC_UNSIGNED_POT_MODE) begin
                potNeg_next = 1'b0;
            end else if (speedZero) begin
                potNeg_next = cmdIn.auxCmd;
            end
        end
        potSigned = potNeg_next ? 16'(-potMag_next) : potMag_next;
        storeData_next = potSigned;
        // Power loss edge writes regardless of the store option so a quick restart can resume
        storeWr_next = (quickRestartEn && powerLoss && !powerPrev_reg)
            || (storeAllowed && !loadPending_reg && (potSigned != storeData_reg));
        rampSeen_next = divStart ? potRampTime : rampSeen_reg;
        stepValid_next = stepValid_reg || divStart;
    end

    always_ff @(posedge clk_sys or negedge rstSync_n) begin
        if (!rstSync_n) begin
            potMag_reg <= `SRS_ZERO_REF;
            potNeg_reg <= 1'b0;
            loadPending_reg <= 1'b1;
            powerPrev_reg <= 1'b0;
            storeWr_reg <= 1'b0;
            storeData_reg <= `SRS_ZERO_REF;
            rampSeen_reg <= `SRS_ZERO_REF;
            stepValid_reg <= 1'b0;
        end else begin
            potMag_reg <= potMag_next;
            potNeg_reg <= potNeg_next;
            loadPending_reg <= loadPending_next;
            powerPrev_reg <= powerPrev_next;
            storeWr_reg <= storeWr_next;
            storeData_reg <= storeData_next;
            rampSeen_reg <= rampSeen_next;
            stepValid_reg <= stepValid_next;
        end
    end

    // Jog selection, reference output and tuning set
    logic parSel;
    logic signed [15:0] jogFirst, jogSecond, jogValue, baseRef;
    logic jogActive;
    logic signed [16:0] addSum;
    logic signed [15:0] speedRef_reg, speedRef_next;
    logic run_reg, run_next;
    logic parTwo_reg, parTwo_next;
    srs_tune_t tune_reg, tune_next;

    assign parSel = (auxCmdFunction == AUX_CMD_FN_PARAM_SET) && cmdIn.auxCmd;
    assign jogFirst = parSel ? jogRefs.jogRefB1 : jogRefs.jogRefA1;
    assign jogSecond = parSel ? jogRefs.jogRefB2 : jogRefs.jogRefA2;
    assign baseRef = potModeOn ? potSigned : externalRef;
    assign addSum = 17'(baseRef) + 17'(jogValue);

    always_comb begin
        jogActive = cmdIn.jogOneCmd || cmdIn.jogTwoCmd;
        if (cmdIn.jogOneCmd) begin
            jogValue = jogFirst;
        end else if (cmdIn.jogTwoCmd) begin
            jogValue = jogSecond;
        end else begin
            jogValue = `SRS_ZERO_REF;
        end
        if (!jogActive) begin
            speedRef_next = baseRef;
        end else if (addRefSource == ADD_REF_INTERNAL) begin
            // Saturate the sum at plus or minus full scale; compares must stay signed
            if (addSum > $signed(FULL17)) begin
                speedRef_next = `SRS_FULL_SCALE;
            end else if (addSum < -$signed(FULL17)) begin
                speedRef_next = 16'(-17'(FULL17));
            end else begin
                speedRef_next = addSum[15:0];
            end
        end else begin
            speedRef_next = jogValue;
        end
        run_next = jogActive || cmdIn.startCmd;
        parTwo_next = parSel;
        tune_next = parSel ? tuneSetB : tuneSetA;
    end

    always_ff @(posedge clk_sys or negedge rstSync_n) begin
        if (!rstSync_n) begin
            speedRef_reg <= `SRS_ZERO_REF;
            run_reg <= 1'b0;
            parTwo_reg <= 1'b0;
            tune_reg <= '0;
        end else begin
            speedRef_reg <= speedRef_next;
            run_reg <= run_next;
            parTwo_reg <= parTwo_next;
            tune_reg <= tune_next;
        end
    end

    assign speedRef = speedRef_reg;
    assign potRef = potNeg_reg ? 16'(-potMag_reg) : potMag_reg;
    assign runEnable = run_reg;
    assign paramSetTwo = parTwo_reg;
    assign tuneActive = tune_reg;
    assign storedReference = storeData_reg;
    assign storedRefWrite = storeWr_reg;

    // Checks
    property p_unsigned_up;
        @(posedge clk_sys) disable iff (!rstSync_n)
        cycleTick && speedRefSource == SRC_UNSIGNED_POT_MODE && potUp && !zeroClear && !loadPending_reg
        |=> (potMag_reg >= $past(potMag_reg)) && !potNeg_reg;
    endproperty
    a_unsigned_up: assert property (p_unsigned_up) else $error("pot did not rise in unsigned mode");

    property p_hold;
        @(posedge clk_sys) disable iff (!rstSync_n)
        cycleTick && !potUp && !potDown && !zeroClear && !loadPending_reg |=> $stable(potMag_reg);
    endproperty
    a_hold: assert property (p_hold) else $error("pot moved with no single command");

    property p_range;
        @(posedge clk_sys) disable iff (!rstSync_n)
        potMag_reg <= `SRS_FULL_SCALE;
    endproperty
    a_range: assert property (p_range) else $error("pot magnitude above full scale");

    property p_sign;
        @(posedge clk_sys) disable iff (!rstSync_n)
        !cycleTick && !loadPending_reg |=> $stable(potNeg_reg);
    endproperty
    a_sign: assert property (p_sign) else $error("pot sign changed off the software cycle");

    property p_zero;
        @(posedge clk_sys) disable iff (!rstSync_n)
        zeroClear && !loadPending_reg |=> potMag_reg == `SRS_ZERO_REF ##1 (storedReference == `SRS_ZERO_REF);
    endproperty
    a_zero: assert property (p_zero) else $error("standstill did not clear the pot");

    property p_jog_one;
        @(posedge clk_sys) disable iff (!rstSync_n)
        cmdIn.jogOneCmd && addRefSource == ADD_REF_NONE |=> speedRef == $past(jogFirst) && runEnable;
    endproperty
    a_jog_one: assert property (p_jog_one) else $error("jog one not applied");

    property p_jog_two;
        @(posedge clk_sys) disable iff (!rstSync_n)
        !cmdIn.jogOneCmd && cmdIn.jogTwoCmd && addRefSource == ADD_REF_NONE |=> speedRef == $past(jogSecond);
    endproperty
    a_jog_two: assert property (p_jog_two) else $error("jog two not applied");

    property p_tune;
        @(posedge clk_sys) disable iff (!rstSync_n)
        auxCmdFunction == AUX_CMD_FN_PARAM_SET && cmdIn.auxCmd |=> paramSetTwo && tuneActive == $past(tuneSetB);
    endproperty
    a_tune: assert property (p_tune) else $error("second tuning set not selected");

    property p_power;
        @(posedge clk_sys) disable iff (!rstSync_n)
        quickRestartEn && $rose(powerLoss) |=> storedRefWrite && storedReference == potRef;
    endproperty
    a_power: assert property (p_power) else $error("power loss did not store the pot");

    property p_tick;
        @(posedge clk_sys) disable iff (!rstSync_n)
        cycleTick |=> !cycleTick [*2];
    endproperty
    a_tick: assert property (p_tick) else $error("software cycle ticks too close");
endmodule

// ===== tb/srs_cmd_panel.sv
// Operator panel model that drives the command terminal levels
`timescale 1ns/1ps
module srs_cmd_panel
    import srs_pkg::*;
(
    // Clock
    input wire logic clk_sys,
    // Terminal levels
    output srs_cmd_t cmdIn
);
    initial begin
        cmdIn = '0;
    end

    // Levels change just after an edge, so the block never samples a half-set pattern
    task automatic setCmd(input srs_cmd_t c);
        @(posedge clk_sys);
        #1;
        cmdIn = c;
    endtask
endmodule

// ===== tb/tb_top.sv
// Self-checking testbench for the speed reference selector
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin nTests++; if ((got) !== (ex)) begin mismatches++; \
$display("CHECK FAILED %s expected %h seen %h", nm, ex, got); end end
module tb_top
    import srs_pkg::*;
;
    logic clk_sys;
    logic rst_n;
    srs_cmd_t cmdIn;
    srs_src_t speedRefSource;
    srs_aux_fn_t auxCmdFunction;
    srs_add_src_t addRefSource;
    logic [15:0] potRampTime;
    logic refStoreEnable, storeJumper, zeroAtStandstill, quickRestartEn;
    srs_jog_t jogRefs;
    srs_tune_t tuneSetA, tuneSetB, tuneActive;
    logic speedZero, powerLoss;
    logic signed [15:0] externalRef, storedReferenceIn, storedReference, speedRef, potRef;
    logic storedRefWrite, runEnable, paramSetTwo, cycleTick;
    int mismatches = 0;
    int nTests = 0;

    // Short software cycle and two cycles per second keep the ramp steps coarse and the run brief
    srs_top #(.SW_CYCLE_CLKS(32'h0000_0008), .CYCLES_PER_S(32'h0000_0002)) i_dut (
        .clk_sys(clk_sys), .rst_n(rst_n), .cmdIn(cmdIn), .speedRefSource(speedRefSource),
        .auxCmdFunction(auxCmdFunction), .addRefSource(addRefSource), .potRampTime(potRampTime),
        .refStoreEnable(refStoreEnable), .storeJumper(storeJumper), .zeroAtStandstill(zeroAtStandstill),
        .quickRestartEn(quickRestartEn), .jogRefs(jogRefs), .tuneSetA(tuneSetA), .tuneSetB(tuneSetB),
        .speedZero(speedZero), .powerLoss(powerLoss), .externalRef(externalRef),
        .storedReferenceIn(storedReferenceIn), .storedReference(storedReference),
        .storedRefWrite(storedRefWrite), .speedRef(speedRef), .potRef(potRef), .runEnable(runEnable),
        .paramSetTwo(paramSetTwo), .tuneActive(tuneActive), .cycleTick(cycleTick)
    );

    srs_cmd_panel i_panel (
        .clk_sys(clk_sys),
        .cmdIn(cmdIn)
    );

    initial begin
        clk_sys = 1'b0;
        forever begin
            #2 clk_sys = ~clk_sys;
        end
    end

    task automatic endOfTest();
        if (mismatches == 0 && nTests > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    task automatic setPanel(input logic inc, dec, aux, j1, j2, st);
        i_panel.setCmd('{inc, dec, aux, j1, j2, st});
    endtask

    // One pot update: wait for the software tick, then check value, write pulse and final reference
    task automatic potStep(input logic aux, inc, dec, input logic [15:0] ex, input logic wr);
        int k;
        setPanel(inc, dec, aux, 1'b0, 1'b0, 1'b0);
        for (k = 0; k < 20 && cycleTick !== 1'b1; k++) begin
            @(posedge clk_sys);
            #1;
        end
        if (k == 20) begin
            mismatches++;
            endOfTest();
        end
        @(posedge clk_sys);
        #1;
        `CHK("potRef", ex, potRef)
        `CHK("storedRefWrite", wr, storedRefWrite)
        if (wr) begin
            `CHK("storedReference", ex, storedReference)
        end
        `CHK("speedRef", ex, speedRef)
        @(posedge clk_sys);
        #1;
        `CHK("storedRefWritePulse", 1'b0, storedRefWrite)
    endtask

    initial begin
        int i, n;
        logic pairB;
        logic signed [15:0] jog, expRef, seen;
        rst_n = 1'b0;
        speedRefSource = SRC_UNSIGNED_POT_MODE;
        auxCmdFunction = AUX_CMD_FN_NONE;
        addRefSource = ADD_REF_NONE;
        potRampTime = 16'h0002;
        refStoreEnable = 1'b1;
        storeJumper = 1'b1;
        zeroAtStandstill = 1'b0;
        quickRestartEn = 1'b0;
        jogRefs = '{16'h0100, 16'h0200, 16'h0300, 16'hFC00};
        tuneSetA = 96'h1001_1002_1003_1004_1005_1006;
        tuneSetB = 96'h2001_2002_2003_2004_2005_2006;
        speedZero = 1'b0;
        powerLoss = 1'b0;
        externalRef = 16'h0123;
        storedReferenceIn = 16'h0800;
        repeat (6) @(posedge clk_sys);
        #1;
        rst_n = 1'b1;
        repeat (40) @(posedge clk_sys);
        #1;
        `CHK("potRef", 16'h0800, potRef)
        // Step is full scale over ramp time in cycles: 0x4000 / (2 * 2)
        potStep(1'b0, 1'b1, 1'b0, 16'h1800, 1'b1);
        potStep(1'b0, 1'b1, 1'b0, 16'h2800, 1'b1);
        potStep(1'b0, 1'b1, 1'b0, 16'h3800, 1'b1);
        potStep(1'b0, 1'b1, 1'b0, 16'h4000, 1'b1);
        potStep(1'b0, 1'b1, 1'b1, 16'h4000, 1'b0);
        potStep(1'b0, 1'b0, 1'b1, 16'h3000, 1'b1);
        potStep(1'b0, 1'b0, 1'b0, 16'h3000, 1'b0);
        zeroAtStandstill = 1'b1;
        speedZero = 1'b1;
        potStep(1'b0, 1'b1, 1'b0, 16'h0000, 1'b1);
        zeroAtStandstill = 1'b0;
        potStep(1'b0, 1'b0, 1'b1, 16'h0000, 1'b0);
        // Signed mode: sign taken only at standstill, then kept while moving
        speedRefSource = SRC_SIGNED_POT_MODE;
        potStep(1'b1, 1'b1, 1'b0, 16'hF000, 1'b1);
        speedZero = 1'b0;
        potStep(1'b0, 1'b1, 1'b0, 16'hE000, 1'b1);
        potStep(1'b0, 1'b0, 1'b1, 16'hF000, 1'b1);
        potStep(1'b0, 1'b1, 1'b1, 16'hF000, 1'b0);
        // Supply loss with quick restart writes the live pot value once
        refStoreEnable = 1'b0;
        quickRestartEn = 1'b1;
        setPanel(1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0);
        powerLoss = 1'b1;
        n = 0;
        seen = 16'h0000;
        repeat (4) begin
            @(posedge clk_sys);
            #1;
            if (storedRefWrite === 1'b1) begin
                n++;
                seen = storedReference;
            end
        end
        `CHK("quickRestartWrites", 1, n)
        `CHK("quickRestartValue", 16'hF000, seen)
        powerLoss = 1'b0;
        quickRestartEn = 1'b0;
        // Every jog, start, aux, set-function and add-source combination
        speedRefSource = SRC_EXTERNAL;
        for (i = 0; i < 64; i++) begin
            setPanel(1'b0, 1'b0, i[4], i[2], i[1], i[0]);
            auxCmdFunction = srs_aux_fn_t'(i[3]);
            addRefSource = srs_add_src_t'(i[5]);
            repeat (2) @(posedge clk_sys);
            #1;
            pairB = i[3] && i[4];
            jog = i[2] ? (pairB ? jogRefs.jogRefB1 : jogRefs.jogRefA1)
                       : (pairB ? jogRefs.jogRefB2 : jogRefs.jogRefA2);
            expRef = !(i[2] || i[1]) ? externalRef : (i[5] ? externalRef + jog : jog);
            `CHK("speedRef", expRef, speedRef)
            `CHK("runEnable", (i[2] || i[1] || i[0]), runEnable)
            `CHK("paramSetTwo", pairB, paramSetTwo)
            `CHK("tuneActive", (pairB ? tuneSetB : tuneSetA), tuneActive)
        end
        // Added jog pushes the sum past full scale and must clip there
        externalRef = 16'h3FF0;
        setPanel(1'b0, 1'b0, 1'b0, 1'b1, 1'b0, 1'b0);
        auxCmdFunction = AUX_CMD_FN_NONE;
        addRefSource = ADD_REF_INTERNAL;
        repeat (2) @(posedge clk_sys);
        #1;
        `CHK("speedRefSat", 16'h4000, speedRef)
        endOfTest();
    end
endmodule
